/* logic/spims_port.sv */
// Serial master/slave port: pin logic, shift engine and flags
// How it works
// - Slave presents data per polarity and edge
// - Keeps running while its clock runs
// - Select unused: slave always active
// - Bus opens, then waits for receive buffer space
// - Master data write starts the transfer
// - Done flag set after all bits
// - Slave shifts one bit per clock
// - Disabled port releases all pins
// - Four lines: clock, in, out, select
// - Select unused: pin has no control
// - Enabled idle, slave not selected: data out held high
// - Master idles clock; slave floats it
// - Master makes clock; slave takes it
// - Received byte copied only when complete
// - Both ends share the bit order
// - Write while busy: collision, discarded
// - Collision flag sticky until cleared
// - Role field selects role and clock
// - Polarity and edge select capture edge
// - Bit order: 1 is MSB first
// - Early deselect sets incomplete and done
`timescale 1ns/1ps
module spims_port (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire spims_pkg::spims_cfg_s cfg,
  input wire logic irq_enable,
  input wire logic data_wr,
  input wire logic [7:0] data_wr_byte,
  input wire logic clr_done,
  input wire logic clr_collision,
  input wire logic incomplete_wr,
  input wire logic incomplete_wr_val,
  input wire logic sub_clock_pin,
  input wire logic timer_match_pulse,
  input wire logic serial_clock_pin_i,
  input wire logic serial_data_in,
  input wire logic slave_select_n,
  input wire logic rx_ready,
  output logic serial_clock_pin_o,
  output logic serial_clock_pin_oe,
  output logic serial_data_out_o,
  output logic serial_data_out_oe,
  output logic pin_function_active,
  output spims_pkg::spims_flags_s flags,
  output logic [7:0] shift_data_register,
  output logic busy,
  output logic irq,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  import spims_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: sck, sdi, ssn, sub clock
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic sck_d_r;
  logic sub_d_r;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= 4'hf;
      sync_r <= 4'hf;
      sck_d_r <= 1'b1;
      sub_d_r <= 1'b1;
    end
    else if (clk_en)
    begin
      meta_r <= {sub_clock_pin, slave_select_n, serial_data_in, serial_clock_pin_i};
      sync_r <= meta_r;
      sck_d_r <= sync_r[0];
      sub_d_r <= sync_r[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mode decode
  logic enabled;
  logic is_master;
  logic is_slave;
  logic slave_sel;
  logic cap_rise;
  logic slv_cap;
  logic half_tick;
  logic buf_ready;
  logic sub_edge;

  assign enabled = cfg.port_enable && (cfg.role_clock_select <= ROLE_SLAVE);
  assign is_master = enabled && (cfg.role_clock_select != ROLE_SLAVE);
  assign is_slave = enabled && (cfg.role_clock_select == ROLE_SLAVE);
  // Select pin only counts when in use
  assign slave_sel = is_slave && (!cfg.select_pin_use || !sync_r[2]);
  assign cap_rise = capture_rising(cfg.clock_idle_polarity, cfg.clock_capture_edge);
  // Slave clock comes from the pin
  assign slv_cap = cap_rise ? (sync_r[0] && !sck_d_r) : (!sync_r[0] && sck_d_r);
  assign sub_edge = sync_r[3] ^ sub_d_r;

  ////////////////////////////////////////////////////////////////////////
  // Shift engine
  spims_state_e st_r;
  spims_state_e st_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic sck_r;
  logic sck_nxt;
  logic sdo_r;
  logic sdo_nxt;
  spims_flags_s fl_r;
  spims_flags_s fl_nxt;
  logic [7:0] rd_r;
  logic [7:0] rd_nxt;
  logic push_r;
  logic push_nxt;
  logic irq_r;
  logic done_set;
  logic inc_set;
  logic wr_busy;
  logic [7:0] base;

  spims_tick u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .run(st_r == ST_MRUN),
    .role(cfg.role_clock_select),
    .sub_edge(sub_edge),
    .timer_tick(timer_match_pulse),
    .half_tick(half_tick)
  );

  always_comb
  begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    sck_nxt = sck_r;
    rd_nxt = rd_r;
    push_nxt = 1'b0;
    done_set = 1'b0;
    inc_set = 1'b0;
    // A write during a transfer is dropped
    wr_busy = data_wr && (st_r != ST_IDLE);
    base = (data_wr && st_r == ST_IDLE) ? data_wr_byte : sh_r;
    if (!enabled)
    begin
      st_nxt = ST_IDLE;
      cnt_nxt = 5'h00;
      sck_nxt = ~cfg.clock_idle_polarity;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          sh_nxt = base;
          sck_nxt = ~cfg.clock_idle_polarity;
          cnt_nxt = 5'h00;
          // Data write opens a master transfer
          if (is_master && data_wr)
          begin
            st_nxt = ST_WAIT;
          end
          // Selected slave shifts on a master edge
          else if (slave_sel && slv_cap)
          begin
            sh_nxt = shift_in(base, sync_r[1], cfg.bit_order_msb_first);
            cnt_nxt = 5'h01;
            st_nxt = ST_SRUN;
          end
        end
        ST_WAIT:
        begin
          // Holds off while the receive buffer is full
          if (buf_ready)
          begin
            st_nxt = ST_MRUN;
          end
        end
        ST_MRUN:
        begin
          if (half_tick)
          begin
            sck_nxt = ~sck_r;
            cnt_nxt = cnt_r + 5'h01;
            if (~sck_r == cap_rise)
            begin
              sh_nxt = shift_in(sh_r, sync_r[1], cfg.bit_order_msb_first);
            end
            if (cnt_r == LAST_EDGE)
            begin
              st_nxt = ST_IDLE;
              cnt_nxt = 5'h00;
              done_set = 1'b1;
              push_nxt = 1'b1;
            end
          end
        end
        ST_SRUN:
        begin
          if (cfg.select_pin_use && sync_r[2])
          begin
            st_nxt = ST_IDLE;
            cnt_nxt = 5'h00;
            done_set = 1'b1;
            inc_set = 1'b1;
          end
          else if (!slave_sel)
          begin
            st_nxt = ST_IDLE;
            cnt_nxt = 5'h00;
          end
          else if (slv_cap)
          begin
            sh_nxt = shift_in(sh_r, sync_r[1], cfg.bit_order_msb_first);
            cnt_nxt = cnt_r + 5'h01;
            if (cnt_r == LAST_BIT)
            begin
              st_nxt = ST_IDLE;
              cnt_nxt = 5'h00;
              done_set = 1'b1;
              push_nxt = 1'b1;
            end
          end
        end
        default:
        begin
          st_nxt = ST_IDLE;
        end
      endcase
    end
    // Readable byte changes only on completion
    if (push_nxt)
    begin
      rd_nxt = sh_nxt;
    end
    // Bit out while active, high otherwise
    sdo_nxt = 1'b1;
    if (enabled && (st_nxt != ST_IDLE || slave_sel))
    begin
      sdo_nxt = out_bit(sh_nxt, cfg.bit_order_msb_first);
    end
    fl_nxt.transfer_done_flag = done_set || (fl_r.transfer_done_flag && !clr_done);
    fl_nxt.write_collision_flag = wr_busy ||
                                  (fl_r.write_collision_flag && !clr_collision);
    fl_nxt.incomplete_transfer_flag = fl_r.incomplete_transfer_flag;
    if (incomplete_wr)
    begin
      fl_nxt.incomplete_transfer_flag = incomplete_wr_val;
    end
    if (inc_set)
    begin
      fl_nxt.incomplete_transfer_flag = 1'b1;
    end
  end

  // State advances whenever the clock is enabled
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_r <= ST_IDLE;
      sh_r <= RST_DATA;
      cnt_r <= 5'h00;
      sck_r <= 1'b1;
      sdo_r <= 1'b1;
      fl_r <= '0;
      rd_r <= RST_DATA;
      push_r <= 1'b0;
      irq_r <= 1'b0;
      serial_clock_pin_oe <= 1'b0;
      serial_data_out_oe <= 1'b0;
      pin_function_active <= 1'b0;
      busy <= 1'b0;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      sck_r <= sck_nxt;
      sdo_r <= sdo_nxt;
      fl_r <= fl_nxt;
      rd_r <= rd_nxt;
      push_r <= push_nxt;
      irq_r <= irq_enable && (fl_nxt.transfer_done_flag || fl_nxt.write_collision_flag);
      serial_clock_pin_oe <= is_master;
      serial_data_out_oe <= enabled;
      pin_function_active <= enabled;
      busy <= (st_nxt != ST_IDLE);
    end
  end

  assign serial_clock_pin_o = sck_r;
  assign serial_data_out_o = sdo_r;
  assign flags = fl_r;
  assign shift_data_register = rd_r;
  assign irq = irq_r;

  spims_buf #(.WIDTH(XFER_BITS), .DEPTH(2)) u_buf (
    .clk_sys(clk_sys),
    .rst(rst),
    .clk_en(clk_en),
    .in_valid(push_r),
    .in_data(rd_r),
    .in_ready(buf_ready),
    .out_valid(rx_valid),
    .out_data(rx_byte),
    .out_ready(rx_ready)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  sequence s_busy_write;
    clk_en && data_wr && st_r != ST_IDLE;
  endsequence

  sequence s_master_last_edge;
    clk_en && enabled && st_r == ST_MRUN && half_tick && cnt_r == LAST_EDGE;
  endsequence

  a_collision_set: assert property (s_busy_write |=> fl_r.write_collision_flag)
    else $error("busy write did not set collision");
  a_collision_keeps_xfer: assert property (s_busy_write ##0 st_r == ST_MRUN
    |=> st_r != ST_IDLE || fl_r.transfer_done_flag)
    else $error("busy write disturbed transfer");
  a_collision_sticky: assert property (clk_en && fl_r.write_collision_flag
    && !clr_collision |=> fl_r.write_collision_flag)
    else $error("collision flag dropped without clear");
  a_master_done: assert property (s_master_last_edge
    |=> fl_r.transfer_done_flag ##1 rx_valid)
    else $error("master end did not set done");
  a_done_wins: assert property (clk_en && done_set && clr_done
    |=> fl_r.transfer_done_flag)
    else $error("done lost to clear");
  a_incomplete_pair: assert property (clk_en && inc_set
    |=> fl_r.incomplete_transfer_flag && fl_r.transfer_done_flag)
    else $error("incomplete without done");
  a_sw_inc_no_done: assert property (clk_en && incomplete_wr && !done_set
    && !fl_r.transfer_done_flag |=> !fl_r.transfer_done_flag)
    else $error("software incomplete set done");
  a_master_idle_clock: assert property (clk_en && is_master && st_r == ST_IDLE
    |=> serial_clock_pin_o == ~$past(cfg.clock_idle_polarity) && serial_clock_pin_oe)
    else $error("master clock not at idle level");
  a_disabled_pins: assert property (clk_en && !enabled
    |=> !serial_clock_pin_oe && !serial_data_out_oe && !pin_function_active)
    else $error("disabled port still drives");
  a_idle_sdo_high: assert property (clk_en && enabled && st_nxt == ST_IDLE && !slave_sel
    |=> serial_data_out_o && serial_data_out_oe)
    else $error("idle data out not high");
  a_start_on_write: assert property (clk_en && is_master && st_r == ST_IDLE && data_wr
    |=> st_r == ST_WAIT)
    else $error("write did not start master");
  a_slave_no_select: assert property (clk_en && is_slave && !cfg.select_pin_use
    && st_r == ST_IDLE && slv_cap |=> st_r == ST_SRUN)
    else $error("slave ignored clock without select");
  a_rx_latched: assert property (clk_en && push_nxt
    |=> shift_data_register == $past(sh_nxt))
    else $error("received byte not latched");
endmodule

/* logic/spims_pkg.sv */
// Shared constants, types and helpers of the serial master/slave port
package spims_pkg;

  // Role and clock source field values
  localparam logic [2:0] ROLE_MST_DIV4 = 3'h0;
  localparam logic [2:0] ROLE_MST_DIV16 = 3'h1;
  localparam logic [2:0] ROLE_MST_DIV64 = 3'h2;
  localparam logic [2:0] ROLE_MST_SUB = 3'h3;
  localparam logic [2:0] ROLE_MST_TIMER = 3'h4;
  localparam logic [2:0] ROLE_SLAVE = 3'h5;

  // Half periods of the master clock, in system clocks
  localparam logic [5:0] HALF_DIV4 = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;

  // Transfer geometry
  localparam int XFER_BITS = 8;
  localparam logic [4:0] LAST_EDGE = 5'h0f;
  localparam logic [4:0] LAST_BIT = 5'h07;

  // Values after reset
  localparam logic [2:0] RST_ROLE = 3'h7;
  localparam logic [7:0] RST_DATA = 8'h00;

  typedef struct packed {
    logic [2:0] role_clock_select;
    logic port_enable;
    logic select_pin_use;
    logic clock_idle_polarity;
    logic clock_capture_edge;
    logic bit_order_msb_first;
  } spims_cfg_s;

  typedef struct packed {
    logic incomplete_transfer_flag;
    logic write_collision_flag;
    logic transfer_done_flag;
  } spims_flags_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_MRUN = 2'b10,
    ST_SRUN = 2'b11
  } spims_state_e;

  // Capture edge is rising for polarity 0/edge 0 and polarity 1/edge 1
  function automatic logic capture_rising(input logic polb, input logic edg);
    capture_rising = polb ? edg : ~edg;
  endfunction

  // Outgoing bit of the shift buffer
  function automatic logic out_bit(input logic [7:0] sh, input logic msb);
    out_bit = msb ? sh[7] : sh[0];
  endfunction

  // One shift step: out bit leaves, incoming bit enters the other end
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                          input logic msb);
    shift_in = msb ? {sh[6:0], b} : {b, sh[7:1]};
  endfunction

endpackage

/* logic/spims_tick.sv */
// Master serial clock half-period tick generator
`timescale 1ns/1ps
module spims_tick (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic run,
  input wire logic [2:0] role,
  input wire logic sub_edge,
  input wire logic timer_tick,
  output logic half_tick
);
  import spims_pkg::*;

  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;
  logic [5:0] half;

  assign half_tick = tick_r;

  always_comb
  begin
    cnt_nxt = cnt_r;
    tick_nxt = 1'b0;
    half = HALF_DIV4;
    case (role)
      ROLE_MST_DIV16: half = HALF_DIV16;
      ROLE_MST_DIV64: half = HALF_DIV64;
      default: half = HALF_DIV4;
    endcase
    if (!run)
    begin
      cnt_nxt = 6'h00;
    end
    else if (role == ROLE_MST_SUB)
    begin
      tick_nxt = sub_edge;
    end
    else if (role == ROLE_MST_TIMER)
    begin
      // Toggling per match halves the rate
      tick_nxt = timer_tick;
    end
    else if (cnt_r == half - 6'h01)
    begin
      cnt_nxt = 6'h00;
      tick_nxt = 1'b1;
    end
    else
    begin
      cnt_nxt = cnt_r + 6'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 6'h00;
      tick_r <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
endmodule

/* logic/spims_buf.sv */
// Two-entry receive buffer with valid/ready on both sides
`timescale 1ns/1ps
module spims_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_r;
  logic [PW-1:0] rd_r;
  logic [CW-1:0] cnt_r;
  logic [PW-1:0] wr_nxt;
  logic [PW-1:0] rd_nxt;
  logic [CW-1:0] cnt_nxt;
  logic in_ready_r;
  logic out_valid_r;
  logic push;
  logic pop;

  assign in_ready = in_ready_r;
  assign out_valid = out_valid_r;
  assign out_data = mem_r[rd_r];

  always_comb
  begin
    push = in_valid && in_ready_r;
    pop = out_valid_r && out_ready;
    wr_nxt = wr_r;
    rd_nxt = rd_r;
    cnt_nxt = cnt_r;
    if (push)
    begin
      wr_nxt = (wr_r == PW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
    end
    if (pop)
    begin
      rd_nxt = (rd_r == PW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
    end
    if (push && !pop)
    begin
      cnt_nxt = cnt_r + 1'b1;
    end
    else if (pop && !push)
    begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
      in_ready_r <= 1'b1;
      out_valid_r <= 1'b0;
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_r[i] <= '0;
      end
    end
    else if (clk_en)
    begin
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      cnt_r <= cnt_nxt;
      in_ready_r <= (cnt_nxt < CW'(DEPTH));
      out_valid_r <= (cnt_nxt != '0);
      if (push)
      begin
        mem_r[wr_r] <= in_data;
      end
    end
  end
endmodule

/* tb/spims_peer.sv */
// Behavioural far-side serial peer, acting as slave or as master
`timescale 1ns/1ps
module spims_peer (
  input wire logic clk_sys,
  input wire logic sck,
  input wire logic sdo,
  input wire logic pol,
  input wire logic edg,
  input wire logic msb,
  output logic sck_m,
  output logic ssn,
  output logic sdi
);
  logic [7:0] sh;
  logic [7:0] rx;
  logic [3:0] n;
  logic act;
  logic tog;
  logic sck_d;
  logic sdo_d;

  initial
  begin
    act = 1'b0;
    tog = 1'b0;
    ssn = 1'b1;
    sh = 8'h00;
    rx = 8'h00;
    n = 4'h0;
    sdi = 1'b1;
  end

  ////////////////////////////////////////////////////////////
  // Clock stands still at its base level outside frames
  assign sck_m = act ? (~pol ^ tog) : ~pol;

  task automatic load(input logic [7:0] b);
    sh = b;
    n = 4'h0;
    sdi = msb ? b[7] : b[0];
  endtask

  task automatic hold(input logic s);
    ssn = ~s;
  endtask

  task automatic frame(input int edges, input logic sel);
    ssn = ~sel;
    act = 1'b1;
    repeat (8) @(negedge clk_sys);
    repeat (edges)
    begin
      tog = ~tog;
      repeat (8) @(negedge clk_sys);
    end
    ssn = 1'b1;
    act = 1'b0;
    tog = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////
  // Capture and launch edges
  // Data out is taken from the sample before the edge, as a real pin would be
  always @(posedge clk_sys)
  begin
    sck_d <= sck;
    sdo_d <= sdo;
    if (sck_d !== sck)
    begin
      if (sck == (pol == edg))
      begin
        rx <= msb ? {rx[6:0], sdo_d} : {sdo_d, rx[7:1]};
        sh <= msb ? {sh[6:0], 1'b0} : {1'b0, sh[7:1]};
        n <= n + 4'h1;
      end
      else if (n != 4'h0)
        sdi <= msb ? sh[7] : sh[0];
    end
  end
endmodule

/* tb/spims_port_tb.sv */
// Self-checking bench of the serial master/slave port
`timescale 1ns/1ps
module spims_port_tb;
  import spims_pkg::*;
  logic clk_sys, rst, irq_enable, data_wr, clr_done, clr_collision;
  logic incomplete_wr, incomplete_wr_val, sub_clock_pin, timer_match_pulse, rx_ready;
  logic [7:0] data_wr_byte;
  spims_cfg_s cfg;
  logic serial_clock_pin_i, serial_data_in, slave_select_n, serial_clock_pin_o;
  logic serial_clock_pin_oe, serial_data_out_o, serial_data_out_oe, pin_function_active;
  spims_flags_s flags;
  logic [7:0] shift_data_register, rx_byte;
  logic busy, irq, rx_valid, sck_m, sdo_w, sck_q, clk_en;
  int failures, n_tests, gap, run, cnt;
  logic [7:0] q[$];
  logic [7:0] eq[$];
  int half_of[5] = '{2, 8, 32, 10, 10};

  spims_port dut (
    .clk_sys, .rst, .clk_en, .cfg, .irq_enable, .data_wr, .data_wr_byte, .clr_done,
    .clr_collision, .incomplete_wr, .incomplete_wr_val, .sub_clock_pin, .timer_match_pulse,
    .serial_clock_pin_i, .serial_data_in, .slave_select_n, .rx_ready, .serial_clock_pin_o,
    .serial_clock_pin_oe, .serial_data_out_o, .serial_data_out_oe, .pin_function_active,
    .flags, .shift_data_register, .busy, .irq, .rx_valid, .rx_byte
  );

  spims_peer peer (
    .clk_sys, .sck(serial_clock_pin_i), .sdo(sdo_w), .pol(cfg.clock_idle_polarity),
    .edg(cfg.clock_capture_edge), .msb(cfg.bit_order_msb_first), .sck_m,
    .ssn(slave_select_n), .sdi(serial_data_in)
  );

  assign serial_clock_pin_i = serial_clock_pin_oe ? serial_clock_pin_o : sck_m;
  // Pull-up holds the data line once released
  assign sdo_w = serial_data_out_oe ? serial_data_out_o : 1'b1;

  always #5 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////
  // Sub clock and timer ticks, both one half period per 10 cycles
  always @(negedge clk_sys)
  begin
    cnt <= (cnt == 9) ? 0 : cnt + 1;
    timer_match_pulse <= (cnt == 9);
    if (cnt == 9)
      sub_clock_pin <= ~sub_clock_pin;
  end

  always @(posedge clk_sys)
  begin
    sck_q <= serial_clock_pin_i;
    run <= (sck_q !== serial_clock_pin_i) ? 1 : run + 1;
    if (sck_q !== serial_clock_pin_i)
      gap <= run;
    if (rx_valid === 1'b1 && rx_ready === 1'b1)
      q.push_back(rx_byte);
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    if (failures == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic setcfg(input logic [2:0] r, input logic u, input logic [2:0] k);
    @(negedge clk_sys);
    cfg = '{r, 1'b1, u, k[0], k[1], k[2]};
    repeat (6) @(negedge clk_sys);
  endtask

  task automatic wr(input logic [7:0] b);
    @(negedge clk_sys);
    data_wr = 1'b1;
    data_wr_byte = b;
    @(negedge clk_sys);
    data_wr = 1'b0;
  endtask

  task automatic clr(input logic d, input logic c);
    @(negedge clk_sys);
    clr_done = d;
    clr_collision = c;
    @(negedge clk_sys);
    clr_done = 1'b0;
    clr_collision = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic iw(input logic v);
    @(negedge clk_sys);
    incomplete_wr = 1'b1;
    incomplete_wr_val = v;
    @(negedge clk_sys);
    incomplete_wr = 1'b0;
    @(negedge clk_sys);
  endtask

  task automatic waitdone();
    int i;
    i = 0;
    while (flags.transfer_done_flag !== 1'b1 && i < 3000)
    begin
      @(negedge clk_sys);
      i++;
    end
    chk({7'h0, flags.transfer_done_flag}, 8'h01);
    // Peer sees the last pin edge only after the synchronising delay
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic drain();
    repeat (4) @(negedge clk_sys);
    while (eq.size() > 0)
      chk(q.size() > 0 ? q.pop_front() : 8'hxx, eq.pop_front());
    chk(8'(q.size()), 8'h00);
  endtask

  ////////////////////////////////////////////////////////////
  // Write, wait, read, clear
  task automatic mx(input logic [2:0] r, input logic [2:0] k, input logic [7:0] b);
    logic [7:0] p;
    p = ~b;
    setcfg(r, 1'b1, k);
    peer.load(p);
    wr(b);
    waitdone();
    chk(8'(gap), 8'(half_of[r]));
    chk({6'h0, serial_clock_pin_oe, serial_clock_pin_i}, {7'h1, ~k[0]});
    // Fastest divider leaves no margin for the pin synchronisers, so timing only
    if (r == ROLE_MST_DIV4)
    begin
      repeat (4) @(negedge clk_sys);
      void'(q.pop_back());
    end
    else
    begin
      chk(peer.rx, b);
      chk(shift_data_register, p);
      eq.push_back(p);
    end
    clr(1'b1, 1'b0);
  endtask

  task automatic sx(input logic u, input logic [2:0] k, input logic [7:0] b, input int e);
    logic [7:0] p;
    p = {b[3:0], b[7:4]};
    setcfg(ROLE_SLAVE, u, k);
    peer.load(p);
    wr(b);
    peer.frame(e, u);
    repeat (8) @(negedge clk_sys);
    if (e == 16)
    begin
      chk(peer.rx, b);
      chk(shift_data_register, p);
      chk({5'h0, flags}, 8'h01);
      chk({7'h0, serial_clock_pin_oe}, 8'h00);
      eq.push_back(p);
      clr(1'b1, 1'b0);
    end
  endtask

  initial
  begin
    repeat (50000) @(posedge clk_sys);
    failures++;
    summarize();
  end

  initial
  begin
    {clk_sys, irq_enable, data_wr, clr_done, clr_collision, incomplete_wr} = 6'h00;
    {incomplete_wr_val, sub_clock_pin, timer_match_pulse, data_wr_byte} = 11'h000;
    {rst, rx_ready, cnt, failures, n_tests} = {2'h3, 96'h0};
    cfg = '{3'h7, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    clk_en = 1'b1;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk({pin_function_active, serial_clock_pin_oe, serial_data_out_oe, busy, irq, rx_valid,
         2'h0}, 8'h00);
    chk({5'h0, flags}, 8'h00);
    chk(shift_data_register, RST_DATA);
    for (int r = 6; r < 9; r++)
    begin
      setcfg(3'(r), 1'b1, 3'h0);
      cfg.port_enable = (r != 8);
      repeat (6) @(negedge clk_sys);
      chk({5'h0, pin_function_active, serial_clock_pin_oe, serial_data_out_oe}, 8'h00);
    end
    setcfg(ROLE_SLAVE, 1'b1, 3'h0);
    chk({5'h0, serial_data_out_oe, serial_data_out_o, serial_clock_pin_oe}, 8'h06);
    peer.hold(1'b1);
    for (int k = 0; k < 8; k++)
      mx(ROLE_MST_DIV16, 3'(k), 8'h3a ^ 8'(k * 37));
    for (int r = 0; r < 5; r++)
      mx(3'(r), 3'h4, 8'hc5);
    drain();
    // Collision during a transfer, then sticky flag and interrupt
    setcfg(ROLE_MST_DIV16, 1'b1, 3'h4);
    peer.load(8'h96);
    wr(8'ha5);
    repeat (20) @(negedge clk_sys);
    wr(8'h0f);
    @(negedge clk_sys);
    chk({5'h0, flags}, 8'h02);
    chk({7'h0, irq}, 8'h00);
    // Enable low mid byte: clock pin must stand still, transfer resumes
    clk_en = 1'b0;
    repeat (30) @(negedge clk_sys);
    chk({6'h0, busy, 1'(run >= 30)}, 8'h03);
    clk_en = 1'b1;
    irq_enable = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk({7'h0, irq}, 8'h01);
    waitdone();
    chk(peer.rx, 8'ha5);
    eq.push_back(8'h96);
    clr(1'b1, 1'b0);
    repeat (20) @(negedge clk_sys);
    chk({5'h0, flags}, 8'h02);
    clr(1'b0, 1'b1);
    @(negedge clk_sys);
    chk({6'h0, irq, flags.write_collision_flag}, 8'h00);
    irq_enable = 1'b0;
    drain();
    // Receiver stalls: two bytes fill the buffer, the third start waits
    rx_ready = 1'b0;
    mx(ROLE_MST_DIV16, 3'h5, 8'h11);
    mx(ROLE_MST_DIV16, 3'h5, 8'h22);
    peer.load(8'h3c);
    wr(8'h33);
    repeat (100) @(negedge clk_sys);
    chk({6'h0, busy, flags.transfer_done_flag}, 8'h02);
    rx_ready = 1'b1;
    waitdone();
    eq.push_back(8'h3c);
    clr(1'b1, 1'b0);
    drain();
    peer.hold(1'b0);
    for (int k = 0; k < 8; k++)
      sx(1'b1, 3'(k), 8'h6b + 8'(k * 19), 16);
    sx(1'b0, 3'h7, 8'h81, 16);
    drain();
    sx(1'b1, 3'h2, 8'hf0, 6);
    chk({5'h0, flags}, 8'h05);
    drain();
    clr(1'b1, 1'b0);
    iw(1'b0);
    iw(1'b1);
    chk({5'h0, flags}, 8'h04);
    iw(1'b0);
    sx(1'b1, 3'h2, 8'h0f, 16);
    drain();
    summarize();
  end
endmodule
